// *** rtl/ppr_pkg.sv ***
// Constants, register map and input enumeration for the pin input routing block.
// Assumes a simple strobe register port with read data one cycle after the read strobe.
package ppr_pkg;
    localparam int ADDR_W = 6;
    localparam int SEL_W = 5;
    localparam int NUM_INPUTS = 18;
    localparam logic [SEL_W-1:0] NUM_PINS = 5'h19;
    localparam logic [SEL_W-1:0] PIN_TEN = 5'h0a;
    localparam int B7_BIT = 7;
    // Own offsets: selection fields at 0x00..0x11
    localparam logic [ADDR_W-1:0] OFS_SEL_BASE = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_PORT_B_PIN_LEVELS_LVL = 6'h20;
    localparam logic [ADDR_W-1:0] OFS_PORT_B_PIN_LEVELS_LAT = 6'h21;
    localparam logic [ADDR_W-1:0] OFS_PORT_B_PIN_LEVELS_DIR = 6'h22;
    localparam logic [ADDR_W-1:0] OFS_ANALOG_HI = 6'h23;
    localparam logic [ADDR_W-1:0] OFS_PAD_CFG = 6'h24;
    localparam logic [ADDR_W-1:0] OFS_PULLUP = 6'h25;
    localparam int PAD_TTL_BIT = 0;
    localparam logic [7:0] PAD_CFG_MASK = 8'h07;
    localparam logic [7:0] ANALOG_HI_MASK = 8'h9f;
    localparam int ANALOG_B7_BIT = 4;
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] ANALOG_RST = 8'h00;
    localparam logic [7:0] PAD_RST = 8'h00;
    localparam logic PULLUP_DIS_RST = 1'b1;
    typedef enum {
        IN_EXT_EXT_INTERRUPT_ONE, IN_EXT_INT2, IN_EXT_INT3, IN_T0_CLK, IN_T3_CLK, IN_T5_CLK,
        IN_CAP1, IN_CAP2, IN_CAP3, IN_T1_GATE, IN_T3_GATE, IN_T5_GATE,
        IN_SER2_RX, IN_SER2_CLK, IN_SPI2_DATA, IN_SPI2_CLK, IN_SPI2_SEL, IN_PWM_FAULT
    } ppr_input_e;
endpackage : ppr_pkg

// *** rtl/ppr_sync.sv ***
// Three-stage pin synchroniser with agreement filter.
// Assumes pin levels are asynchronous to mclk.
`timescale 1ns/1ps
module ppr_sync #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } ppr_sync_s;
    ppr_sync_s st_r;
    ppr_sync_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        // A change counts only once stages two and three agree
        for (int k = 0; k < W; k++) begin
            if (st_r.s2[k] == st_r.s3[k]) begin
                st_nxt.q[k] = st_r.s3[k];
            end
        end
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign q = st_r.q;
endmodule : ppr_sync

// *** rtl/ppr_sel_mem.sv ***
// Storage for the peripheral input selection fields, registered read.
// Assumes one write and one read port on mclk.
`timescale 1ns/1ps
module ppr_sel_mem #(
    parameter int N = 18,
    parameter int W = 5,
    parameter int AW = 5
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata,
    output logic [N*W-1:0] fields
);
    typedef struct packed {
        logic [N-1:0][W-1:0] f;
        logic [W-1:0] rd;
    } ppr_mem_s;
    ppr_mem_s st_r;
    ppr_mem_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        if (we && (32'(waddr) < N)) begin
            st_nxt.f[waddr] = wdata;
        end
        st_nxt.rd = (32'(raddr) < N) ? st_r.f[raddr] : '0;
    end
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign rdata = st_r.rd;
    assign fields = st_r.f;
endmodule : ppr_sel_mem

// *** rtl/ppr_top.sv ***
// Pin input routing: selection fabric, port-B bit seven pad, parallel port buffer select.
// Assumes pad buffers are modelled by per-pin Schmitt and TTL level inputs from the pad ring.
`timescale 1ns/1ps
module ppr_top #(
    parameter int NPIN = 25
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [NPIN-1:0] remap_pin_st,
    input wire logic [7:0] port_b_pin_ttl,
    input wire logic [NPIN-1:0] remap_pin_out,
    input wire logic [7:0] pport_pin_st,
    input wire logic [7:0] pport_pin_ttl,
    input wire logic debug_active,
    input wire logic debug_data_oe,
    input wire logic debug_data_out,
    output logic debug_data_in,
    output logic port_b_bit_seven_o,
    output logic port_b_bit_seven_oe,
    output logic port_b_bit_seven_pullup,
    output logic port_b_bit_seven_analog,
    output logic pport_ttl_select,
    output logic [7:0] pport_in,
    output logic [ppr_pkg::NUM_INPUTS-1:0] periph_in
);
    typedef struct packed {
        logic [7:0] lat;
        logic [7:0] dir;
        logic [7:0] analog;
        logic [7:0] pad;
        logic pullup_disable_n;
        logic [7:0] rdata;
        logic [ppr_pkg::NUM_INPUTS-1:0] pin_route;
        logic [7:0] pport;
        logic dbg_in;
        logic rd_sel;
    } ppr_top_s;
    ppr_top_s st_r;
    ppr_top_s st_nxt;
    logic [NPIN-1:0] pin_st_s;
    logic [7:0] b_ttl_s;
    logic [7:0] pp_st_s;
    logic [7:0] pp_ttl_s;
    logic [4:0] mem_rdata;
    logic [ppr_pkg::NUM_INPUTS*ppr_pkg::SEL_W-1:0] fields;
    logic sel_wr;
    logic [4:0] sel_idx;
    logic [NPIN-1:0] pin_level;
    logic [7:0] port_b_lvl;

    function automatic logic in_sel_range(input logic [5:0] a);
        in_sel_range = (a >= ppr_pkg::OFS_SEL_BASE)
            && (32'(a - ppr_pkg::OFS_SEL_BASE) < ppr_pkg::NUM_INPUTS);
    endfunction : in_sel_range

    ppr_sync #(.W(NPIN)) u_sync_pin (
        .mclk(mclk),
        .rst(rst),
        .d(remap_pin_st),
        .q(pin_st_s)
    );
    ppr_sync #(.W(24)) u_sync_misc (
        .mclk(mclk),
        .rst(rst),
        .d({port_b_pin_ttl, pport_pin_st, pport_pin_ttl}),
        .q({b_ttl_s, pp_st_s, pp_ttl_s})
    );

    // Codes beyond the implemented pins are dropped, keeping the old selection
    assign sel_wr = reg_wr && in_sel_range(reg_addr)
        && (reg_wdata[4:0] < ppr_pkg::NUM_PINS) && (reg_wdata[7:5] == 3'h0);
    assign sel_idx = 5'(reg_addr - ppr_pkg::OFS_SEL_BASE);

    ppr_sel_mem #(.N(ppr_pkg::NUM_INPUTS), .W(ppr_pkg::SEL_W), .AW(5)) u_sel (
        .mclk(mclk),
        .rst(rst),
        .we(sel_wr),
        .waddr(sel_idx),
        .wdata(reg_wdata[4:0]),
        .raddr(sel_idx),
        .rdata(mem_rdata),
        .fields(fields)
    );

    // Analog pins read as zero until configured digital
    always_comb begin
        pin_level = pin_st_s;
        if (!st_r.analog[ppr_pkg::ANALOG_B7_BIT]) begin
            pin_level[ppr_pkg::PIN_TEN] = 1'b0;
        end
        // Remap pin ten reads only while its direction is input
        if (!st_r.dir[ppr_pkg::B7_BIT] || debug_active) begin
            pin_level[ppr_pkg::PIN_TEN] = 1'b0;
        end
    end

    always_comb begin
        port_b_lvl = b_ttl_s;
        port_b_lvl[ppr_pkg::B7_BIT] = st_r.analog[ppr_pkg::ANALOG_B7_BIT]
            && st_r.dir[ppr_pkg::B7_BIT] && b_ttl_s[ppr_pkg::B7_BIT];
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.rdata = 8'h00;
        if (reg_wr) begin
            case (reg_addr)
                ppr_pkg::OFS_PORT_B_PIN_LEVELS_LVL: st_nxt.lat = reg_wdata;
                ppr_pkg::OFS_PORT_B_PIN_LEVELS_LAT: st_nxt.lat = reg_wdata;
                ppr_pkg::OFS_PORT_B_PIN_LEVELS_DIR: st_nxt.dir = reg_wdata;
                ppr_pkg::OFS_ANALOG_HI: st_nxt.analog = reg_wdata & ppr_pkg::ANALOG_HI_MASK;
                ppr_pkg::OFS_PAD_CFG: st_nxt.pad = reg_wdata & ppr_pkg::PAD_CFG_MASK;
                ppr_pkg::OFS_PULLUP: st_nxt.pullup_disable_n = reg_wdata[0];
                default: st_nxt.lat = st_r.lat;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ppr_pkg::OFS_PORT_B_PIN_LEVELS_LVL: st_nxt.rdata = port_b_lvl;
                ppr_pkg::OFS_PORT_B_PIN_LEVELS_LAT: st_nxt.rdata = st_r.lat;
                ppr_pkg::OFS_PORT_B_PIN_LEVELS_DIR: st_nxt.rdata = st_r.dir;
                ppr_pkg::OFS_ANALOG_HI: st_nxt.rdata = st_r.analog;
                ppr_pkg::OFS_PAD_CFG: st_nxt.rdata = st_r.pad;
                ppr_pkg::OFS_PULLUP: st_nxt.rdata = {7'h00, st_r.pullup_disable_n};
                default: st_nxt.rdata = 8'h00;
            endcase
        end
        // Each input picks its own pin; sharing a pin is allowed
        for (int k = 0; k < ppr_pkg::NUM_INPUTS; k++) begin
            st_nxt.pin_route[k] = pin_level[fields[k*ppr_pkg::SEL_W +: ppr_pkg::SEL_W]];
        end
        if (st_r.pad[ppr_pkg::PAD_TTL_BIT]) begin
            st_nxt.pport = pp_ttl_s;
        end else begin
            st_nxt.pport = pp_st_s;
        end
        st_nxt.dbg_in = pin_st_s[ppr_pkg::PIN_TEN];
        // Selection reads come from the field memory, which answers on the same edge
        st_nxt.rd_sel = reg_rd && in_sel_range(reg_addr);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r.lat <= ppr_pkg::LAT_RST;
            st_r.dir <= ppr_pkg::DIR_RST;
            st_r.analog <= ppr_pkg::ANALOG_RST;
            st_r.pad <= ppr_pkg::PAD_RST;
            st_r.pullup_disable_n <= ppr_pkg::PULLUP_DIS_RST;
            st_r.rdata <= 8'h00;
            st_r.pin_route <= '0;
            st_r.pport <= 8'h00;
            st_r.dbg_in <= 1'b0;
            st_r.rd_sel <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Pad drive: debug mode owns the pin, else direction sets the enable and latch OR remapped output drives it
    always_comb begin
        if (debug_active) begin
            port_b_bit_seven_oe = debug_data_oe;
            port_b_bit_seven_o = debug_data_out;
        end else begin
            port_b_bit_seven_oe = !st_r.dir[ppr_pkg::B7_BIT];
            // Latch drives the pin; remapped output rides on it when the peripheral uses pin ten
            port_b_bit_seven_o = st_r.lat[ppr_pkg::B7_BIT] | remap_pin_out[ppr_pkg::PIN_TEN];
        end
    end
    assign port_b_bit_seven_pullup = !st_r.pullup_disable_n && st_r.dir[ppr_pkg::B7_BIT]
        && !debug_active;
    assign port_b_bit_seven_analog = !st_r.analog[ppr_pkg::ANALOG_B7_BIT] && !debug_active;
    assign pport_ttl_select = st_r.pad[ppr_pkg::PAD_TTL_BIT];
    assign pport_in = st_r.pport;
    assign periph_in = st_r.pin_route;
    assign debug_data_in = st_r.dbg_in;
    assign reg_rdata = st_r.rd_sel ? {3'h0, mem_rdata} : st_r.rdata;
endmodule : ppr_top

// *** tb/ppr_properties.sv ***
// Checker for the pin input routing block, bound to ppr_top.
// Assumes a single mclk domain with rst asynchronous and active high.
`timescale 1ns/1ps
module ppr_properties #(
    parameter int NPIN = 25
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [NPIN-1:0] remap_pin_st,
    input wire logic [7:0] pport_pin_st,
    input wire logic [7:0] pport_pin_ttl,
    input wire logic debug_active,
    input wire logic debug_data_oe,
    input wire logic debug_data_out,
    input wire logic debug_data_in,
    input wire logic port_b_bit_seven_o,
    input wire logic port_b_bit_seven_oe,
    input wire logic port_b_bit_seven_analog,
    input wire logic pport_ttl_select,
    input wire logic [7:0] pport_in
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence wr_sel0;
        reg_wr && reg_addr == 6'h00 && reg_wdata < 8'h19;
    endsequence
    sequence rd_sel0;
        reg_rd && !reg_wr && reg_addr == 6'h00;
    endsequence
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data seen outside the read cycle");
    chk_sel_readback: assert property (wr_sel0 ##2 rd_sel0 |=> reg_rdata == $past(reg_wdata, 3))
        else $error("selection field did not read back");
    chk_dbg_dir: assert property (debug_active |-> port_b_bit_seven_oe == debug_data_oe)
        else $error("debug mode does not own pin direction");
    chk_dbg_drive: assert property (debug_active && debug_data_oe |-> port_b_bit_seven_o == debug_data_out)
        else $error("debug data not driven on pin");
    chk_ttl_path: assert property ((pport_ttl_select && $stable(pport_pin_ttl)) [*8] |-> pport_in == pport_pin_ttl)
        else $error("parallel port not on TTL buffers");
    chk_st_path: assert property ((!pport_ttl_select && $stable(pport_pin_st)) [*8] |-> pport_in == pport_pin_st)
        else $error("parallel port not on Schmitt buffers");
    chk_dbg_input: assert property ((debug_active && $stable(remap_pin_st[10])) [*8] |-> debug_data_in == remap_pin_st[10])
        else $error("debug data input does not follow pin");
    chk_reset_state: assert property ($fell(rst) |-> port_b_bit_seven_analog && !pport_ttl_select && !port_b_bit_seven_oe)
        else $error("pin state after reset wrong");
endmodule : ppr_properties
bind ppr_top ppr_properties #(.NPIN(NPIN)) chk_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .remap_pin_st(remap_pin_st), .pport_pin_st(pport_pin_st),
    .pport_pin_ttl(pport_pin_ttl), .debug_active(debug_active), .debug_data_oe(debug_data_oe),
    .debug_data_out(debug_data_out), .debug_data_in(debug_data_in), .port_b_bit_seven_o(port_b_bit_seven_o),
    .port_b_bit_seven_oe(port_b_bit_seven_oe), .port_b_bit_seven_analog(port_b_bit_seven_analog),
    .pport_ttl_select(pport_ttl_select), .pport_in(pport_in));

// *** tb/ppr_pad_model.sv ***
// Pad ring model: external pin levels seen through Schmitt and TTL buffers.
// Assumes the bench sets external levels; marginal levels pass TTL but not Schmitt.
`timescale 1ns/1ps
module ppr_pad_model (
    input wire logic mclk,
    input wire logic [24:0] ext_lvl,
    input wire logic ext10_en,
    input wire logic [7:0] pp_lvl,
    input wire logic [7:0] pp_marg,
    input wire logic b7_o,
    input wire logic b7_oe,
    input wire logic b7_pu,
    output logic [24:0] remap_pin_st,
    output logic [7:0] port_b_pin_ttl,
    output logic [7:0] pport_pin_st,
    output logic [7:0] pport_pin_ttl
);
    logic flt = 1'b0;
    logic pin10;
    // Undriven pin without pull-up toggles so a stale value never passes
    always @(posedge mclk) flt <= ~flt;
    assign pin10 = b7_oe ? b7_o : ext10_en ? ext_lvl[10] : b7_pu ? 1'b1 : flt;
    assign remap_pin_st = {ext_lvl[24:11], pin10, ext_lvl[9:0]};
    assign port_b_pin_ttl = {pin10, ext_lvl[6:0]};
    assign pport_pin_ttl = pp_lvl | pp_marg;
    assign pport_pin_st = pp_lvl & ~pp_marg;
endmodule : ppr_pad_model

// *** tb/ppr_top_tb.sv ***
// Self-checking bench for ppr_top with the pad ring model.
// Assumes the strobe register port and a 25 MHz mclk.
`timescale 1ns/1ps
module ppr_top_tb;
    logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, ext10_en = 1'b1;
    logic dbg_act = 1'b0, dbg_oe = 1'b0, dbg_out = 1'b0, b7_o, b7_oe, b7_pu, b7_an, ttl_sel, dbg_in;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00, pp_lvl = 8'h00, pp_marg = 8'h00, reg_rdata, pport_in, pb_ttl, pp_st, pp_ttl, v;
    logic [24:0] ext_lvl = 25'h0, rpin_out = 25'h0, rpin_st;
    logic [17:0] periph_in;
    int fails = 0, n_tests = 0;
    always #20 mclk = ~mclk;
    ppr_top dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .remap_pin_st(rpin_st), .port_b_pin_ttl(pb_ttl),
        .remap_pin_out(rpin_out), .pport_pin_st(pp_st), .pport_pin_ttl(pp_ttl), .debug_active(dbg_act),
        .debug_data_oe(dbg_oe), .debug_data_out(dbg_out), .debug_data_in(dbg_in), .port_b_bit_seven_o(b7_o),
        .port_b_bit_seven_oe(b7_oe), .port_b_bit_seven_pullup(b7_pu), .port_b_bit_seven_analog(b7_an),
        .pport_ttl_select(ttl_sel), .pport_in(pport_in), .periph_in(periph_in));
    ppr_pad_model pad_u (.mclk(mclk), .ext_lvl(ext_lvl), .ext10_en(ext10_en), .pp_lvl(pp_lvl), .pp_marg(pp_marg),
        .b7_o(b7_o), .b7_oe(b7_oe), .b7_pu(b7_pu), .remap_pin_st(rpin_st), .port_b_pin_ttl(pb_ttl),
        .pport_pin_st(pp_st), .pport_pin_ttl(pp_ttl));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // A gap cycle follows each write so strobe lines never get two assignments at one edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [5:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        // Read data stand for the one cycle after the strobe; take them at the edge that ends it
        @(posedge mclk);
        v = reg_rdata;
    endtask : rd
    // Covers the three-flop synchroniser, agreement stage and output register
    task automatic settle;
        repeat (8) @(posedge mclk);
    endtask : settle
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    initial begin
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(6'h21);
        chk("latch", v, ppr_pkg::LAT_RST);
        rd(6'h22);
        chk("dir", v, ppr_pkg::DIR_RST);
        rd(6'h23);
        chk("analog_cfg", v, 8'h00);
        chk("analog_pin", b7_an, 1'b1);
        rd(6'h24);
        chk("pad_cfg", v, 8'h00);
        rd(6'h30);
        chk("unmapped", v, 8'h00);
        for (int i = 0; i < 18; i++) begin
            rd(6'(i));
            chk("sel_reset", v, 8'h00);
            wr(6'(i), 8'(i + 1));
            rd(6'(i));
            chk("sel_field", v, 8'(i + 1));
        end
        wr(6'h00, 8'h19);
        rd(6'h00);
        chk("sel_refused", v, 8'h01);
        wr(6'h23, 8'h10);
        chk("digital_pin", b7_an, 1'b0);
        for (int p = 0; p < 2; p++) begin
            ext_lvl <= p ? ~25'h0aaaaaa : 25'h0aaaaaa;
            settle();
            chk("route", periph_in, p ? 18'h2aaaa : 18'h15555);
        end
        for (int i = 0; i < 18; i++) wr(6'(i), 8'h0a);
        for (int p = 0; p < 2; p++) begin
            ext_lvl <= p ? 25'h0000400 : 25'h0;
            settle();
            chk("shared_pin", periph_in, p ? 18'h3ffff : 18'h0);
        end
        ext10_en <= 1'b0;
        wr(6'h21, 8'h80);
        wr(6'h22, 8'h7f);
        settle();
        chk("b7_drive", {b7_oe, b7_o, periph_in}, {2'b11, 18'h0});
        wr(6'h21, 8'h00);
        rpin_out <= 25'h0000400;
        settle();
        chk("remap_out", b7_o, 1'b1);
        wr(6'h22, 8'hff);
        wr(6'h25, 8'h00);
        settle();
        rd(6'h20);
        chk("pullup", {b7_pu, v[7]}, 2'b11);
        wr(6'h25, 8'h01);
        chk("pullup_off", b7_pu, 1'b0);
        wr(6'h22, 8'h7f);
        dbg_act <= 1'b1;
        dbg_out <= 1'b1;
        settle();
        chk("dbg_float", {b7_oe, periph_in}, 19'h0);
        dbg_oe <= 1'b1;
        settle();
        chk("dbg_drive", {b7_oe, b7_o, dbg_in, periph_in}, {3'b111, 18'h0});
        dbg_act <= 1'b0;
        dbg_oe <= 1'b0;
        pp_lvl <= 8'h5a;
        pp_marg <= 8'h0f;
        wr(6'h24, 8'h01);
        settle();
        chk("ttl_in", {ttl_sel, pport_in}, {1'b1, 8'h5f});
        wr(6'h24, 8'h00);
        settle();
        chk("st_in", {ttl_sel, pport_in}, {1'b0, 8'h50});
        close_out();
    end
    initial begin
        #1000000;
        fails++;
        close_out();
    end
endmodule : ppr_top_tb
